/* rtl/sbc_mode_state_machine.sv */
/*
  Operating-mode sequencer of the supply chip: six modes, MCU reset output,
  regulator enable, watchdog window, straps and a 16-bit SPI frame port.
  Assumes an SPI front end delivering whole frames as one-cycle strobes on
  CORE_CLK, and analogue monitors delivering levels from other domains.
*/
`timescale 1ns/1ps
`include "sbc_mode_defines.svh"
module sbc_mode_state_machine
  import sbc_mode_pkg::*;
#(
  parameter int RELEASE_CYCLES = `RESTART_RELEASE_CYCLES,
  parameter int LONG_WINDOW_CYCLES = `LONG_OPEN_WINDOW_CYCLES
) (
  input wire logic CORE_CLK, // 200 MHz core clock
  input wire logic RESETN, // Power-on reset, low active
  input wire logic [`FRAME_BITS-1:0] FRAME_DATA, // Received SPI frame
  input wire logic FRAME_VALID, // Frame strobe, one cycle
  input wire logic FRAME_MODE_WR, // Frame writes mode control
  input wire logic WD_TRIGGER, // Watchdog served, one cycle
  input wire logic SOFT_RESET, // Soft reset request, one cycle
  input wire logic WAKE_EVENT, // Wake from CAN, LIN or wake pin (pin)
  input wire logic REG_UNDERVOLT, // Main regulator undervoltage (pin)
  input wire logic REG_OVERVOLT, // Main regulator overvoltage (pin)
  input wire logic OVERTEMP, // Overtemperature present (pin)
  input wire logic FAIL3_DEVMODE_STRAP_PIN, // Strap pin, low selects devmode
  input wire logic INT_CFG_STRAP_PIN, // Interrupt/config strap pin
  output logic MCU_RESET_OUTPUT_N, // Reset to MCU, low active
  output logic MAIN_REGULATOR_OUTPUT_EN, // Main regulator enable
  output logic [5:0] MODE_STATE, // One-hot active mode
  output logic [1:0] MODE_FIELD, // Mode field read-back
  output logic DEV_MODE, // Development mode stored
  output logic CFG_STRAP, // Failure-behaviour strap stored
  output logic WD_FAIL, // Watchdog failure flag, sticky until power-on reset
  output logic WD_RUNNING // Watchdog counter running
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  localparam int NPINS = 6;
  sbc_pin_sync_if #(.W(NPINS)) pins_if ();
  // Dev strap enters inverted: the flops reset to 0, which must mean normal
  // operation, else a false development selection appears after reset.
  assign pins_if.raw = {INT_CFG_STRAP_PIN, !FAIL3_DEVMODE_STRAP_PIN, OVERTEMP,
                        REG_OVERVOLT, REG_UNDERVOLT, WAKE_EVENT};
  sbc_pin_sync #(.W(NPINS)) u_sync (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .pins(pins_if.sync)
  );
  wire wake_s = pins_if.synced[0];
  wire uv_s = pins_if.synced[1];
  wire ov_s = pins_if.synced[2];
  wire ot_s = pins_if.synced[3];
  wire devstrap_s = pins_if.synced[4];
  wire cfgstrap_s = pins_if.synced[5];

  //////////////////////////////////////////////////////////////////////////////
  // State and counters

  sbc_mode_e state_q, state_d;
  logic [1:0] mode_q, mode_d;
  logic [31:0] rel_cnt_q, rel_cnt_d;
  logic [31:0] wd_cnt_q, wd_cnt_d;
  logic dev_q, dev_d;
  logic cfg_q, cfg_d;
  logic wdf_q, wdf_d;
  logic wdf_count_q, wdf_count_d;
  logic rst_out_q, rst_out_d;
  logic pwr_up_q;
  logic fs_ot_q, fs_ot_d;

  // Frame decode
  wire [1:0] req_mode = FRAME_DATA[`MODE_LSB+1:`MODE_LSB];
  wire mode_wr = FRAME_VALID && FRAME_MODE_WR;
  wire req_legal = (req_mode == `MODE_FIELD_NORMAL) || (req_mode == `MODE_FIELD_SLEEP) ||
                   (req_mode == `MODE_FIELD_STOP) || (req_mode == `MODE_FIELD_RESET);

  // Watchdog: halted in development mode and outside Init
  wire wd_active = !dev_q && (state_q == ST_INIT);
  wire wd_expire = wd_active && !WD_TRIGGER &&
                   (wd_cnt_q == 32'(LONG_WINDOW_CYCLES - 1));
  wire critical = wd_expire || uv_s;
  // With no pull-up strap, undervoltage or a repeated watchdog failure goes to
  // Fail-Safe; the first watchdog failure, held in wdf_count_q, goes to Restart.
  wire to_failsafe = critical && !cfg_q && (wdf_count_q || uv_s);
  wire rel_done = (rel_cnt_q == 32'(RELEASE_CYCLES - 1));

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    rel_cnt_d = 32'h0;
    wd_cnt_d = 32'h0;
    dev_d = dev_q;
    cfg_d = cfg_q;
    wdf_d = wdf_q;
    wdf_count_d = wdf_count_q;
    rst_out_d = rst_out_q;
    fs_ot_d = fs_ot_q;
    if (wd_active && !WD_TRIGGER) begin
      wd_cnt_d = wd_cnt_q + 32'h1;
    end
    unique case (state_q)
      ST_INIT: begin
        if (pwr_up_q) begin
          dev_d = devstrap_s;
        end
        if (wd_expire) begin
          wdf_d = 1'b1;
          wdf_count_d = 1'b1;
          state_d = to_failsafe ? ST_FAILSAFE : ST_RESTART;
          rst_out_d = 1'b0;
        end else if (FRAME_VALID) begin
          state_d = ST_NORMAL;
          rst_out_d = 1'b1;
        end
      end
      ST_NORMAL, ST_STOP: begin
        if (critical) begin
          state_d = to_failsafe ? ST_FAILSAFE : ST_RESTART;
          rst_out_d = 1'b0;
        end else if (mode_wr && req_legal) begin
          mode_d = req_mode;
          unique case (req_mode)
            `MODE_FIELD_SLEEP: state_d = ST_SLEEP;
            `MODE_FIELD_STOP: state_d = ST_STOP;
            `MODE_FIELD_RESET: begin
              state_d = ST_INIT;
              wd_cnt_d = 32'h0;
            end
            default: state_d = ST_NORMAL;
          endcase
        end
      end
      ST_SLEEP: begin
        if (wake_s) begin
          state_d = ST_RESTART;
          rst_out_d = 1'b0;
        end
      end
      ST_RESTART: begin
        mode_d = `RESET_MODE_FIELD;
        rst_out_d = 1'b0;
        if (!critical && !uv_s) begin
          rel_cnt_d = rel_done ? rel_cnt_q : rel_cnt_q + 32'h1;
          if (rel_done) begin
            state_d = ST_NORMAL;
            rst_out_d = 1'b1;
            if (!pwr_up_q) begin
              cfg_d = cfg_q;
            end
          end
        end
      end
      ST_FAILSAFE: begin
        if (ot_s) begin
          fs_ot_d = 1'b1;
        end
        if (wake_s || (fs_ot_q && !ot_s)) begin
          state_d = ST_RESTART;
          fs_ot_d = 1'b0;
        end
      end
    endcase
    // Strap configuration follows the first release of the reset output
    if (pwr_up_q && !rst_out_q && rst_out_d) begin
      cfg_d = cfgstrap_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= ST_INIT;
      mode_q <= `RESET_MODE_FIELD;
      rel_cnt_q <= 32'h0;
      wd_cnt_q <= 32'h0;
      dev_q <= 1'b0;
      cfg_q <= 1'b0;
      wdf_q <= 1'b0;
      wdf_count_q <= 1'b0;
      rst_out_q <= 1'b0;
      fs_ot_q <= 1'b0;
    end else if (SOFT_RESET) begin
      state_q <= ST_INIT;
      mode_q <= `RESET_MODE_FIELD;
      rel_cnt_q <= 32'h0;
      wd_cnt_q <= 32'h0;
      dev_q <= dev_q;
      cfg_q <= cfg_q;
      wdf_q <= wdf_q;
      wdf_count_q <= wdf_count_q;
      rst_out_q <= rst_out_q;
      fs_ot_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      rel_cnt_q <= rel_cnt_d;
      wd_cnt_q <= wd_cnt_d;
      dev_q <= dev_d;
      cfg_q <= cfg_d;
      wdf_q <= wdf_d;
      wdf_count_q <= wdf_count_d;
      rst_out_q <= rst_out_d;
      fs_ot_q <= fs_ot_d;
    end
  end

  // Power-on phase: straps are captured until the reset output first rises
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pwr_up_q <= 1'b1;
    end else if (rst_out_q) begin
      pwr_up_q <= 1'b0;
    end
  end

  // Reset output: held low after power-on until Init releases it
  logic init_rel_q;
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      init_rel_q <= 1'b0;
    end else begin
      init_rel_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  logic reg_en_q;
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      reg_en_q <= 1'b1;
    end else begin
      // Off only in Sleep and Fail-Safe; Stop keeps it on
      reg_en_q <= !(state_d == ST_SLEEP || state_d == ST_FAILSAFE);
    end
  end

  assign MCU_RESET_OUTPUT_N = rst_out_q || (init_rel_q && state_q == ST_INIT);
  assign MAIN_REGULATOR_OUTPUT_EN = reg_en_q;
  assign MODE_STATE = state_q;
  assign MODE_FIELD = mode_q;
  assign DEV_MODE = dev_q;
  assign CFG_STRAP = cfg_q;
  assign WD_FAIL = wdf_q;
  assign WD_RUNNING = wd_active;

  wire unused_ov = ov_s;
endmodule // sbc_mode_state_machine

/* rtl/sbc_mode_defines.svh */
/*
  Constants of the operating-mode sequencer: mode codes, delays, frame width.
  Assumes a 200 MHz core clock; times are in microseconds.
*/
// Function
// - Exactly six modes: Init, Normal, Stop, Sleep, Restart, Fail-Safe.
// - Init at power-up and after a soft reset.
// - Stop mode keeps the main regulator output on.
// - Sleep mode switches the main regulator output off.
// - Wake in Sleep/Fail-Safe or failure enters Restart and resets the MCU.
// - Restart goes to Normal after release delay once failure cleared.
// - Critical failure may enter Fail-Safe with regulator output off.
// - Fail-Safe holds until a wake event or overtemperature ends.
// - Development mode halts the watchdog counter.
// - Strap low during Init selects development mode, stored at power-on.
// - Development mode still reaches all six modes.
// - Configuration exchanged in 16-bit SPI frames.
// - Mode changes requested through the mode field of mode control.
// - Mode field cleared when passing through Restart.
// - Init begins once supply passes the power-on rise threshold.
// - Entering Init starts watchdog with long open window.
// - Failure behaviour configuration latched from interrupt/config strap.
// - Any SPI frame in Init moves to Normal.
// - No trigger within long open window in Init: failure, Restart.
// - Strap configuration stored at rising edge of reset output.
`ifndef SBC_MODE_DEFINES_SVH
`define SBC_MODE_DEFINES_SVH
`define FRAME_BITS 16
`define MODE_LSB 14
`define MODE_FIELD_NORMAL 2'h0
`define MODE_FIELD_SLEEP 2'h1
`define MODE_FIELD_STOP 2'h2
`define MODE_FIELD_RESET 2'h3
`define CLK_MHZ 200
`define RESTART_RELEASE_DELAY_US 10
`define RESTART_RELEASE_CYCLES (`RESTART_RELEASE_DELAY_US * `CLK_MHZ)
`define LONG_OPEN_WINDOW_TIME_US 200000
`define LONG_OPEN_WINDOW_CYCLES (`LONG_OPEN_WINDOW_TIME_US * `CLK_MHZ)
`define RESET_MODE_FIELD 2'h0
`endif

/* rtl/sbc_mode_pkg.sv */
/*
  Types shared by the mode sequencer. Assumes the defines header alongside.
*/
package sbc_mode_pkg;
  typedef enum logic [5:0] {
    ST_INIT     = 6'b000001,
    ST_NORMAL   = 6'b000010,
    ST_STOP     = 6'b000100,
    ST_SLEEP    = 6'b001000,
    ST_RESTART  = 6'b010000,
    ST_FAILSAFE = 6'b100000
  } sbc_mode_e;
endpackage

/* rtl/sbc_pin_sync_if.sv */
/*
  Carrier between the top module and its pin synchroniser.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface sbc_pin_sync_if #(parameter int W = 8);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport sync (input raw, output synced);
  modport user (output raw, input synced);
endinterface // sbc_pin_sync_if

/* rtl/sbc_pin_sync.sv */
/*
  Two-flop synchroniser for every asynchronous pin of the sequencer.
  Assumes the pins are slow levels; pulses shorter than one clock may vanish.
*/
`timescale 1ns/1ps
module sbc_pin_sync #(
  parameter int W = 8
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Async reset, low active
  sbc_pin_sync_if.sync pins // Raw in, synced out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pins.raw;
      sync_q <= meta_q;
    end
  end
  assign pins.synced = sync_q;
endmodule // sbc_pin_sync

/* test/sbc_mode_asserts.sv */
/* Port checker of the mode sequencer.
   Assumes a bind to the top module and one clock. */
`timescale 1ns/1ps
module sbc_mode_asserts
  import sbc_mode_pkg::*;
#(
  parameter int RELEASE_CYCLES = 4
) (
  input wire logic CORE_CLK, // Core clock
  input wire logic RESETN, // Reset, low active
  input wire logic FRAME_VALID, // Frame strobe
  input wire logic WAKE_EVENT, // Wake level
  input wire logic MCU_RESET_OUTPUT_N, // MCU reset
  input wire logic MAIN_REGULATOR_OUTPUT_EN, // Regulator on
  input wire logic [5:0] MODE_STATE, // Active mode
  input wire logic [1:0] MODE_FIELD, // Mode field
  input wire logic DEV_MODE, // Dev mode
  input wire logic WD_RUNNING // Watchdog running
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  int stay_q;
  wire restart = MODE_STATE == ST_RESTART;
  // Restart length, read on the first Normal cycle
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      stay_q <= 0;
    end else begin
      stay_q <= restart ? stay_q + 1 : 0;
    end
  end
////////////////////////////////////////
  onehot_mode_a: assert property ($onehot(MODE_STATE))
    else $error("mode not one-hot");
  stop_reg_on_a: assert property ((MODE_STATE == ST_STOP)[*2] |-> MAIN_REGULATOR_OUTPUT_EN)
    else $error("regulator off in stop");
  sleep_reg_off_a: assert property ((MODE_STATE == ST_SLEEP)[*2] |-> !MAIN_REGULATOR_OUTPUT_EN)
    else $error("regulator on in sleep");
  failsafe_reg_off_a: assert property ((MODE_STATE == ST_FAILSAFE)[*2] |-> !MAIN_REGULATOR_OUTPUT_EN)
    else $error("regulator on in fail-safe");
  restart_reset_a: assert property (restart |-> !MCU_RESET_OUTPUT_N)
    else $error("reset released in restart");
  restart_field_a: assert property (restart[*2] |-> MODE_FIELD == 2'h0)
    else $error("mode field kept in restart");
  wake_restart_a: assert property ($rose(WAKE_EVENT) && MODE_STATE == ST_SLEEP |-> ##[1:4] restart)
    else $error("wake did not restart");
  release_delay_a: assert property ($past(restart) && MODE_STATE == ST_NORMAL
    |-> stay_q inside {[RELEASE_CYCLES:RELEASE_CYCLES + 3]})
    else $error("restart length wrong");
  init_frame_a: assert property (MODE_STATE == ST_INIT && FRAME_VALID |=> MODE_STATE == ST_NORMAL)
    else $error("frame in init ignored");
  devmode_wd_a: assert property (DEV_MODE |-> !WD_RUNNING)
    else $error("watchdog runs in dev mode");
endmodule // sbc_mode_asserts

bind sbc_mode_state_machine sbc_mode_asserts #(.RELEASE_CYCLES(RELEASE_CYCLES)) u_sbc_mode_asserts (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .FRAME_VALID(FRAME_VALID), .WAKE_EVENT(WAKE_EVENT),
  .MCU_RESET_OUTPUT_N(MCU_RESET_OUTPUT_N), .MAIN_REGULATOR_OUTPUT_EN(MAIN_REGULATOR_OUTPUT_EN),
  .MODE_STATE(MODE_STATE), .MODE_FIELD(MODE_FIELD), .DEV_MODE(DEV_MODE), .WD_RUNNING(WD_RUNNING));

/* test/host_mcu_model.sv */
/* Host microcontroller: whole frames and watchdog service.
   Assumes the core clock and the sequencer reset output. */
`timescale 1ns/1ps
module host_mcu_model (
  input wire logic clk, // Core clock
  input wire logic mcu_reset_n, // Reset from sequencer
  output logic [15:0] frame_data, // Frame word
  output logic frame_valid, // Frame strobe
  output logic frame_mode_wr, // Mode write
  output logic wd_trigger // Watchdog service
);
  initial begin
    frame_data = 16'hA5A5;
    {frame_valid, frame_mode_wr, wd_trigger} = 3'h0;
  end
  task automatic send(input logic wr, input logic [15:0] data);
    int n;
    n = 0;
    while (mcu_reset_n !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    frame_data <= data;
    frame_mode_wr <= wr;
    frame_valid <= 1'b1;
    @(negedge clk);
    frame_valid <= 1'b0;
    frame_mode_wr <= 1'b0;
    // Idle bus shows garbage, not the last word
    frame_data <= ~data;
  endtask
  task automatic kick();
    @(negedge clk);
    wd_trigger <= 1'b1;
    @(negedge clk);
    wd_trigger <= 1'b0;
  endtask
endmodule // host_mcu_model

/* test/sbc_mode_state_machine_test.sv */
/* Bench of the mode sequencer with a bench mode model.
   Assumes shortened release and window counts. */
`timescale 1ns/1ps
module sbc_mode_state_machine_test
  import sbc_mode_pkg::*;
;
  localparam int REL = 4;
  localparam int WIN = 16;
  logic CORE_CLK, RESETN, FRAME_VALID, FRAME_MODE_WR, WD_TRIGGER, SOFT_RESET, WAKE_EVENT;
  logic REG_UNDERVOLT, REG_OVERVOLT, OVERTEMP, FAIL3_DEVMODE_STRAP_PIN, INT_CFG_STRAP_PIN;
  logic MCU_RESET_OUTPUT_N, MAIN_REGULATOR_OUTPUT_EN, DEV_MODE, CFG_STRAP, WD_FAIL, WD_RUNNING;
  logic [15:0] FRAME_DATA;
  logic [5:0] MODE_STATE;
  logic [1:0] MODE_FIELD;
  int mismatches = 0;
  int tests_run = 0;
  int seed;
  sbc_mode_e exp_mode;
  sbc_mode_state_machine #(.RELEASE_CYCLES(REL), .LONG_WINDOW_CYCLES(WIN)) u_sbc_mode_state_machine (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .FRAME_DATA(FRAME_DATA), .FRAME_VALID(FRAME_VALID),
    .FRAME_MODE_WR(FRAME_MODE_WR), .WD_TRIGGER(WD_TRIGGER), .SOFT_RESET(SOFT_RESET),
    .WAKE_EVENT(WAKE_EVENT), .REG_UNDERVOLT(REG_UNDERVOLT), .REG_OVERVOLT(REG_OVERVOLT),
    .OVERTEMP(OVERTEMP), .FAIL3_DEVMODE_STRAP_PIN(FAIL3_DEVMODE_STRAP_PIN),
    .INT_CFG_STRAP_PIN(INT_CFG_STRAP_PIN), .MCU_RESET_OUTPUT_N(MCU_RESET_OUTPUT_N),
    .MAIN_REGULATOR_OUTPUT_EN(MAIN_REGULATOR_OUTPUT_EN), .MODE_STATE(MODE_STATE),
    .MODE_FIELD(MODE_FIELD), .DEV_MODE(DEV_MODE), .CFG_STRAP(CFG_STRAP), .WD_FAIL(WD_FAIL),
    .WD_RUNNING(WD_RUNNING));
  host_mcu_model u_host_mcu_model (.clk(CORE_CLK), .mcu_reset_n(MCU_RESET_OUTPUT_N),
    .frame_data(FRAME_DATA), .frame_valid(FRAME_VALID), .frame_mode_wr(FRAME_MODE_WR),
    .wd_trigger(WD_TRIGGER));
  initial begin
    CORE_CLK = 1'b0;
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end
////////////////////////////////////////
  task automatic check(input string what, input logic [5:0] exp, input logic [5:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_state();
    check("mode", exp_mode, MODE_STATE);
    check("regulator", 6'(!(exp_mode inside {ST_SLEEP, ST_FAILSAFE})), 6'(MAIN_REGULATOR_OUTPUT_EN));
  endtask
  task automatic wait_mode(input sbc_mode_e m, input int lim);
    int n;
    n = 0;
    while (MODE_STATE !== m && n < lim) begin
      @(negedge CORE_CLK);
      n++;
    end
    exp_mode = m;
    check_state();
  endtask
  task automatic write_mode(input logic wr, input logic [1:0] f);
    logic ok;
    ok = wr && exp_mode inside {ST_NORMAL, ST_STOP};
    u_host_mcu_model.send(wr, {f, 14'($random(seed))});
    if (ok) begin
      exp_mode = f == 2'h0 ? ST_NORMAL : f == 2'h1 ? ST_SLEEP : f == 2'h2 ? ST_STOP : ST_INIT;
    end else if (exp_mode == ST_INIT) begin
      exp_mode = ST_NORMAL;
    end
    repeat (3) @(negedge CORE_CLK);
    check_state();
    if (ok && f != 2'h3) begin
      check("field", 6'(f), 6'(MODE_FIELD));
    end
  endtask
  task automatic restart_done();
    wait_mode(ST_NORMAL, REL + 20);
    check("reset out", 6'(1'b1), 6'(MCU_RESET_OUTPUT_N));
    check("field", 6'h0, 6'(MODE_FIELD));
  endtask
  task automatic wake();
    WAKE_EVENT = 1'b1;
    wait_mode(ST_RESTART, 8);
    WAKE_EVENT = 1'b0;
    restart_done();
  endtask
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
////////////////////////////////////////
  // The whole run is under three hundred cycles; this limit of 4000 cycles is about thirteen times that
  initial begin
    #20000;
    mismatches++;
    print_verdict();
  end
  initial begin
    seed = 32'h352ED353;
    RESETN = 1'b0;
    {SOFT_RESET, WAKE_EVENT, REG_UNDERVOLT, OVERTEMP, INT_CFG_STRAP_PIN} = 5'h0;
    REG_OVERVOLT = 1'b0;
    FAIL3_DEVMODE_STRAP_PIN = 1'b1;
    exp_mode = ST_INIT;
    repeat (5) @(negedge CORE_CLK);
    RESETN = 1'b1;
    REG_OVERVOLT = 1'($random(seed));
    repeat (2) @(negedge CORE_CLK);
    check_state();
    check("wd running", 6'h1, 6'(WD_RUNNING));
    wait_mode(ST_RESTART, WIN + 20);
    check("wd fail", 6'h1, 6'(WD_FAIL));
    restart_done();
    u_host_mcu_model.kick();
    write_mode(1'b1, 2'h2);
    write_mode(1'b0, 2'h1);
    write_mode(1'b1, 2'h0);
    write_mode(1'b1, 2'h1);
    write_mode(1'b1, 2'h0);
    wake();
    write_mode(1'b1, 2'h3);
    write_mode(1'b0, 2'($random(seed)));
    SOFT_RESET = 1'b1;
    @(negedge CORE_CLK);
    SOFT_RESET = 1'b0;
    wait_mode(ST_INIT, 4);
    write_mode(1'b1, 2'($random(seed)));
    REG_UNDERVOLT = 1'b1;
    wait_mode(ST_FAILSAFE, 8);
    check("cfg strap", 6'h0, 6'(CFG_STRAP));
    REG_UNDERVOLT = 1'b0;
    repeat (20) @(negedge CORE_CLK);
    write_mode(1'b1, 2'h0);
    wake();
    FAIL3_DEVMODE_STRAP_PIN = 1'b0;
    RESETN = 1'b0;
    @(negedge CORE_CLK);
    RESETN = 1'b1;
    repeat (WIN + 20) @(negedge CORE_CLK);
    wait_mode(ST_INIT, 1);
    check("dev mode", 6'h1, 6'(DEV_MODE));
    write_mode(1'b1, 2'h0);
    write_mode(1'b1, 2'h1);
    print_verdict();
  end
endmodule // sbc_mode_state_machine_test
